/* endpoint_receive_status_pkg.sv */
// Purpose: Shared constants and carriers for the endpoint receive status block
// Assumes: APB slave with 32-bit data, one aligned word per register
// Notes:   Printed offset 0xE2 is not a multiple of four, so it is an index
package rx_status_pkg;
    // ==========================================================
    // Register map (indices; byte address is four times index)
    localparam logic [7:0]  IDX_RX_STATUS   = 8'hE2;
    localparam logic [7:0]  IDX_EP_SELECT   = 8'hE3;
    localparam logic [7:0]  IDX_EP_CONTROL  = 8'hE4;
    localparam logic [7:0]  IDX_FIFO_FLAGS  = 8'hE5;
    localparam logic [1:0]  ADDR_LSB_ZERO   = 2'h0;
    localparam logic [7:0]  RX_STATUS_RESET = 8'h00;
    // Endpoint control reset: endpoint 0 starts as a control endpoint
    localparam logic [7:0]  EP0_CTL_RESET   = 8'h04;
    localparam logic [7:0]  EP_CTL_RESET    = 8'h00;
    // ==========================================================
    // Receive status bit positions
    localparam int B_TOGGLE  = 7;
    localparam int B_SETUP   = 6;
    localparam int B_OVW_ST  = 5;
    localparam int B_OVW_END = 4;
    localparam int B_TOG_OVW = 3;
    localparam int B_VOID    = 2;
    localparam int B_ERR     = 1;
    localparam int B_ACK     = 0;
    // Endpoint control bit positions (block-local register)
    localparam int C_RX_STALL = 0;
    localparam int C_TX_STALL = 1;
    localparam int C_CTRL_EP  = 2;
    localparam int C_ISO      = 3;
    // Value forced onto the toggle after a SETUP token
    localparam logic SETUP_TOGGLE_VALUE = 1'b0;
    // ==========================================================
    // Handshake codes to the engine
    typedef enum logic [1:0] {
        HS_NONE  = 2'h0,
        HS_ACK   = 2'h1,
        HS_NAK   = 2'h2,
        HS_STALL = 2'h3
    } handshake_t;
    // Transaction event from the serial interface engine
    typedef struct packed {
        logic       setup_tok;   // Valid SETUP token seen
        logic       out_tok;     // Valid OUT token seen
        logic       in_tok;      // Valid IN token seen
        logic       hs_done;     // Handshake transmission finished
        logic       rx_end;      // End of data reception
        logic       rx_good;     // Data stored completely, ACK sent
        logic       rx_bad;      // CRC, bit stuffing or FIFO overrun/underrun
        logic       sof;         // Start of frame
        logic [1:0] ep;          // Endpoint addressed
    } sie_event_t;
endpackage : rx_status_pkg

/* rx_ep_status.sv */
// Purpose: Status state of one endpoint's receive side
// Assumes: Events shared by all endpoints; hit marks those addressed to this endpoint
// Notes:   Isochronous outcome waits in a pending copy until start of frame
`timescale 1ns/1ps
module rx_ep_status (
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    // Engine events for this endpoint
    input  wire rx_status_pkg::sie_event_t ev,
    input  wire logic                  hit,
    input  wire logic                  rx_stall,
    input  wire logic                  ctrl_ep,
    input  wire logic                  iso,
    // CPU write to the status register of this endpoint
    input  wire logic                  wr,
    input  wire logic [7:0]            wdata,
    // State
    output logic [7:0]                 status,
    output logic                       fifo_locked,
    output logic                       done_set
);
    import rx_status_pkg::*;

    logic tog_r, tog_nxt, setup_r, setup_nxt, ovs_r, ovs_nxt, ove_r, ove_nxt;
    logic void_r, void_nxt, err_r, err_nxt, ack_r, ack_nxt;
    logic pend_r, pend_nxt, pv_r, pv_nxt, pe_r, pe_nxt, pa_r, pa_nxt;
    logic in_setup_r, in_setup_nxt;

    // Outcome of the reception that just ended
    wire tok      = hit & (ev.setup_tok | ev.out_tok);
    wire rx_fin   = hit & ev.rx_end;
    wire o_void   = fifo_locked | (rx_stall & ~in_setup_r);
    wire o_err    = ev.rx_bad;
    wire o_ack    = ev.rx_good & ~ev.rx_bad;   // Never both
    wire setup_hs = hit & ev.hs_done & in_setup_r;
    wire ack_out  = hit & ev.hs_done & ~in_setup_r & ev.rx_good;

    assign fifo_locked = ovs_r | ove_r;
    assign status = {tog_r, setup_r, ovs_r, ove_r, 1'b0, void_r, err_r, ack_r};
    assign done_set = (rx_fin & ~iso & (o_err | o_ack))
                    | (ev.sof & pend_r & (pe_r | pa_r));

    // Next-state logic; hardware sets win over CPU clears
    always_comb begin
        tog_nxt = tog_r;
        setup_nxt = setup_r;
        ovs_nxt = ovs_r;
        ove_nxt = ove_r;
        void_nxt = void_r;
        err_nxt = err_r;
        ack_nxt = ack_r;
        pend_nxt = pend_r;
        pv_nxt = pv_r;
        pe_nxt = pe_r;
        pa_nxt = pa_r;
        in_setup_nxt = in_setup_r;
        // CPU side first so that hardware events override it
        if (wr) begin
            if (wdata[B_TOG_OVW])
                tog_nxt = wdata[B_TOGGLE];
            if (!wdata[B_SETUP])
                setup_nxt = 1'b0;               // Firmware clears it
            if (!wdata[B_OVW_END])
                ove_nxt = 1'b0;
        end
        if (ack_out)
            tog_nxt = ~tog_r;
        if (hit & ev.setup_tok) begin
            tog_nxt = SETUP_TOGGLE_VALUE;
            setup_nxt = 1'b1;
            in_setup_nxt = 1'b1;
            if (ctrl_ep)
                ovs_nxt = 1'b1;
        end
        if (setup_hs) begin
            ovs_nxt = 1'b0;
            in_setup_nxt = 1'b0;
            if (ctrl_ep)
                ove_nxt = 1'b1;
        end
        if (rx_fin) begin
            if (iso) begin
                pend_nxt = 1'b1;
                pv_nxt = o_void;
                pe_nxt = o_err;
                pa_nxt = o_ack;
            end else begin
                void_nxt = o_void;
                err_nxt = o_err;
                ack_nxt = o_ack;
            end
        end
        // Frame start is broadcast, so it does not depend on the endpoint
        if (ev.sof & pend_r) begin
            pend_nxt = 1'b0;
            void_nxt = pv_r;
            err_nxt = pe_r;
            ack_nxt = pa_r;
        end
        if (tok & ~ev.setup_tok & ~rx_fin)
            in_setup_nxt = in_setup_r;
    end

    // State registers, all zero from reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            {tog_r, setup_r, ovs_r, ove_r} <= 4'h0;
            {void_r, err_r, ack_r, in_setup_r} <= 4'h0;
            {pend_r, pv_r, pe_r, pa_r} <= 4'h0;
        end else begin
            {tog_r, setup_r, ovs_r, ove_r} <= {tog_nxt, setup_nxt, ovs_nxt,
                                               ove_nxt};
            {void_r, err_r, ack_r, in_setup_r} <= {void_nxt, err_nxt, ack_nxt,
                                                   in_setup_nxt};
            {pend_r, pv_r, pe_r, pa_r} <= {pend_nxt, pv_nxt, pe_nxt, pa_nxt};
        end
    end
endmodule : rx_ep_status

/* usb_endpoint_receive_status.sv */
// Operation
// - Toggle inverts after each ACK handshake for an OUT token.
// - SETUP token forces the toggle to a fixed hardware value.
// - CPU write changes toggle only with toggle-overwrite bit written one.
// - Toggle-overwrite bit is not stored and reads zero.
// - SETUP sets setup-received; then IN and OUT tokens get NAK.
// - Setup-received makes NAK win over either stall control.
// - SETUP on control endpoint sets overwrite-start and locks FIFO state.
// - Setup handshake end clears overwrite-start; CPU cannot write it.
// - Setup handshake sets overwrite-end; lock holds until firmware clears.
// - Void set when FIFO locked or receive stalled, else cleared; receive stall is ignored while a SETUP transaction is open.
// - Void updates at transaction end, isochronous at next frame start.
// - CRC, stuffing or FIFO fault sets error and gives no handshake.
// - Ack flag set when packet stored and ACK sent.
// - Error and ack update together, exclusive, and set receive-done.
// - Error and ack update at end, isochronous at next frame start.
// - One eight-bit status per endpoint, selected by index, resets zero.
// - Receive stall gives STALL to OUT unless setup-received is set.
//
// Purpose: Receive status of all endpoints behind one APB window
// Assumes: Engine gives one-cycle event pulses on SYS_CLK
// Notes:   Handshake choice is combinational from the token pulse
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps
module usb_endpoint_receive_status #(
    parameter int NUM_EP = 4
) (
    // Clock and reset
    input  wire logic                   SYS_CLK,
    input  wire logic                   RSTN,
    // APB slave
    input  wire logic                   PSEL,
    input  wire logic                   PENABLE,
    input  wire logic                   PWRITE,
    input  wire logic [11:0]            PADDR,
    input  wire logic [31:0]            PWDATA,
    output logic      [31:0]            PRDATA,
    output logic                        PREADY,
    output logic                        PSLVERR,
    // Serial interface engine
    input  wire rx_status_pkg::sie_event_t SIE_EV,
    output rx_status_pkg::handshake_t      HANDSHAKE,
    output logic                        FIFO_LOCKED
);
    import rx_status_pkg::*;

    // ==========================================================
    // APB decode
    logic [1:0]        sel_r, sel_nxt;
    logic [7:0]        ctl_r [NUM_EP];
    logic [NUM_EP-1:0] done_r, done_nxt;
    logic [31:0]       rdata_r, rdata_nxt;
    logic              rd_pend_r, rd_pend_nxt;
    logic [7:0]        stat   [NUM_EP];
    logic [NUM_EP-1:0] lock, dset;

    wire        acc    = PSEL & PENABLE;
    wire        wr     = acc & PWRITE;
    wire [7:0]  idx    = PADDR[9:2];
    wire        al     = (PADDR[1:0] == ADDR_LSB_ZERO)
                       & (PADDR[11:10] == 2'h0);    // Full decode, no aliases
    wire        hit_st = al & (idx == IDX_RX_STATUS);
    wire        hit_sl = al & (idx == IDX_EP_SELECT);
    wire        hit_ct = al & (idx == IDX_EP_CONTROL);
    wire        hit_ff = al & (idx == IDX_FIFO_FLAGS);
    wire        mapped = hit_st | hit_sl | hit_ct | hit_ff;

    // Reads wait one cycle so that read data comes from a flop, not logic;
    // writes finish at once. Unmapped addresses answer with an error.
    wire        rd_acc = acc & ~PWRITE;
    assign rd_pend_nxt = rd_acc & ~rd_pend_r;
    assign PREADY  = ~rd_acc | rd_pend_r;
    assign PSLVERR = acc & ~mapped;
    assign PRDATA  = rdata_r;

    // Read data; toggle-overwrite bit is zero in the status image
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        if (hit_st)
            rdata_nxt[7:0] = stat[sel_r];
        else if (hit_sl)
            rdata_nxt[1:0] = sel_r;
        else if (hit_ct)
            rdata_nxt[7:0] = ctl_r[sel_r];
        else if (hit_ff)
            rdata_nxt[NUM_EP-1:0] = done_r;
    end

    // Done flags: set wins over a write-one-to-clear
    always_comb begin
        done_nxt = done_r;
        if (wr & hit_ff)
            done_nxt = done_r & ~PWDATA[NUM_EP-1:0];
        done_nxt = done_nxt | dset;
        sel_nxt = (wr & hit_sl) ? PWDATA[1:0] : sel_r;
    end

    // Bus-side registers
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            sel_r     <= 2'h0;
            done_r    <= '0;
            rdata_r   <= 32'h0000_0000;
            rd_pend_r <= 1'b0;
        end else begin
            sel_r     <= sel_nxt;
            done_r    <= done_nxt;
            rd_pend_r <= rd_pend_nxt;
            // Load in the first access cycle, then hold for the ready edge
            if (rd_pend_nxt)
                rdata_r <= rdata_nxt;
        end
    end

    // Control registers per endpoint; endpoint 0 defaults to control type
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            for (int i = 0; i < NUM_EP; i++)
                ctl_r[i] <= (i == 0) ? EP0_CTL_RESET : EP_CTL_RESET;
        end else if (wr & hit_ct) begin
            ctl_r[sel_r] <= PWDATA[7:0];
        end
    end

    // ==========================================================
    // Per-endpoint status instances
    wire [NUM_EP-1:0] ep_wr;
    genvar g;
    generate
        for (g = 0; g < NUM_EP; g++) begin : g_ep
            assign ep_wr[g] = wr & hit_st & (sel_r == 2'(g));
            rx_ep_status u_ep (
                .clk         (SYS_CLK),
                .rst_n       (RSTN),
                .ev          (SIE_EV),
                .hit         (SIE_EV.ep == 2'(g)),
                .rx_stall    (ctl_r[g][C_RX_STALL]),
                .ctrl_ep     (ctl_r[g][C_CTRL_EP]),
                .iso         (ctl_r[g][C_ISO]),
                .wr          (ep_wr[g]),
                .wdata       (PWDATA[7:0]),
                .status      (stat[g]),
                .fifo_locked (lock[g]),
                .done_set    (dset[g])
            );
        end
    endgenerate

    // ==========================================================
    // Handshake choice for the addressed endpoint
    wire [7:0] est  = stat[SIE_EV.ep];
    wire [7:0] ectl = ctl_r[SIE_EV.ep];
    always_comb begin
        HANDSHAKE = HS_NONE;
        if (SIE_EV.in_tok | SIE_EV.out_tok) begin
            if (est[B_SETUP])
                HANDSHAKE = HS_NAK;
            else if (SIE_EV.out_tok & ectl[C_RX_STALL])
                HANDSHAKE = HS_STALL;
            else if (SIE_EV.in_tok & ectl[C_TX_STALL])
                HANDSHAKE = HS_STALL;
            else if (SIE_EV.out_tok & lock[SIE_EV.ep])
                HANDSHAKE = HS_NAK;
        end else if (SIE_EV.rx_end) begin
            // Faulty reception gets no handshake at all
            HANDSHAKE = SIE_EV.rx_bad ? HS_NONE : HS_ACK;
        end
    end

    // Lock seen by the receive FIFO pointer logic
    assign FIFO_LOCKED = lock[SIE_EV.ep];
endmodule : usb_endpoint_receive_status

/* usb_endpoint_receive_status_monitor.sv */
// Purpose: Port-level checks of the receive status block
// Assumes: Status word at byte 0x388, endpoint 0 stays a control endpoint
// Notes:   Flag history is judged by the bench; here only port relations
`timescale 1ns/1ps
module rx_status_monitor (
    // Clock and reset
    input wire logic                   SYS_CLK,
    input wire logic                   RSTN,
    // APB
    input wire logic                   PSEL,
    input wire logic                   PENABLE,
    input wire logic                   PWRITE,
    input wire logic [11:0]            PADDR,
    input wire logic [31:0]            PWDATA,
    input wire logic [31:0]            PRDATA,
    input wire logic                   PREADY,
    input wire logic                   PSLVERR,
    // Engine side
    input wire rx_status_pkg::sie_event_t SIE_EV,
    input wire rx_status_pkg::handshake_t HANDSHAKE,
    input wire logic                   FIFO_LOCKED
);
    import rx_status_pkg::*;
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RSTN);
    // ==========================================================
    // Decode helpers
    wire acc   = PSEL && PENABLE;
    wire mapd  = PADDR inside {12'h388, 12'h38C, 12'h390, 12'h394};
    wire st_rd = acc && !PWRITE && (PADDR == 12'h388);
    wire tok   = SIE_EV.setup_tok || SIE_EV.out_tok || SIE_EV.in_tok;
    // ==========================================================
    // Bus and handshake relations
    a_write_ready: assert property (acc && PWRITE |-> PREADY)
        else $error("write not answered at once");
    a_read_wait: assert property ($rose(acc && !PWRITE)
        |-> !PREADY ##1 PREADY)
        else $error("read wait state wrong");
    a_unmapped_err: assert property (acc && !mapd |-> PSLVERR)
        else $error("no error on unmapped word");
    a_mapped_clean: assert property (acc && mapd |-> !PSLVERR)
        else $error("error on mapped word");
    a_read_hold: assert property (!(acc && !PWRITE) |=> $stable(PRDATA))
        else $error("read data moved without a read");
    a_status_shape: assert property (st_rd |=> PRDATA[31:8] == 24'h0
        && !PRDATA[B_TOG_OVW] && !(PRDATA[B_ERR] && PRDATA[B_ACK]))
        else $error("bad status word shape");
    a_bad_silent: assert property (SIE_EV.rx_end && SIE_EV.rx_bad
        |-> HANDSHAKE == HS_NONE)
        else $error("handshake on bad packet");
    a_idle_quiet: assert property (!tok && !SIE_EV.rx_end
        |-> HANDSHAKE == HS_NONE)
        else $error("handshake without cause");
    // Lock raised by a SETUP and kept until a CPU write may end it
    a_setup_lock: assert property (SIE_EV.setup_tok && SIE_EV.ep == 2'h0
        |=> SIE_EV.ep != 2'h0 || FIFO_LOCKED)
        else $error("setup did not lock");
    a_lock_holds: assert property (FIFO_LOCKED && !(acc && PWRITE)
        ##1 SIE_EV.ep == $past(SIE_EV.ep) |-> FIFO_LOCKED)
        else $error("lock dropped without a write");
endmodule : rx_status_monitor
bind usb_endpoint_receive_status rx_status_monitor mon_u (
    .SYS_CLK(SYS_CLK), .RSTN(RSTN), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .SIE_EV(SIE_EV),
    .HANDSHAKE(HANDSHAKE), .FIFO_LOCKED(FIFO_LOCKED));

/* usb_endpoint_receive_status_tb.sv */
// Purpose: Self-checking bench for the endpoint receive status block
// Assumes: Reads get one wait state; the master waits on ready
// Notes:   Endpoint 0 is kept a control endpoint throughout
`timescale 1ns/1ps
module usb_endpoint_receive_status_tb;
    import rx_status_pkg::*;
    localparam logic [7:0]  K_SET = 8'h80, K_OUT = 8'h40, K_IN = 8'h20;
    localparam logic [7:0]  K_HS = 8'h10, K_END = 8'h08, K_OK = 8'h04;
    localparam logic [7:0]  K_BAD = 8'h02, K_SOF = 8'h01;
    localparam logic [11:0] A_ST = 12'h388, A_SEL = 12'h38C;
    localparam logic [11:0] A_CTL = 12'h390, A_FF = 12'h394;
    logic        SYS_CLK = 1'b0;
    logic        RSTN = 1'b0;
    logic        PSEL = 1'b0;
    logic        PENABLE = 1'b0;
    logic        PWRITE = 1'b0;
    logic [11:0] PADDR = 12'h000;
    logic [31:0] PWDATA = 32'h0;
    logic [31:0] PRDATA;
    logic        PREADY;
    logic        PSLVERR;
    sie_event_t  SIE_EV;
    handshake_t  HANDSHAKE;
    logic        FIFO_LOCKED;
    int          n_errors = 0;
    int          cmp_count = 0;
    always #50 SYS_CLK = ~SYS_CLK;
    usb_endpoint_receive_status #(.NUM_EP(4)) dut_u (
        .SYS_CLK(SYS_CLK), .RSTN(RSTN), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
        .PREADY(PREADY), .PSLVERR(PSLVERR), .SIE_EV(SIE_EV),
        .HANDSHAKE(HANDSHAKE), .FIFO_LOCKED(FIFO_LOCKED));
    usb_host_model host_u (.clk(SYS_CLK), .hs(HANDSHAKE), .ev(SIE_EV));
    // ==========================================================
    // Compare, bus and event tasks
    task automatic chk(input string n, input logic [31:0] x,
                       input logic [31:0] g);
        cmp_count++;
        if (g !== x) begin
            n_errors++;
            $display("unexpected %s: expected %0h seen %0h", n, x, g);
        end
    endtask : chk
    task automatic apb(input logic [11:0] a, input logic w,
                       input logic [7:0] d, output logic [31:0] r,
                       output logic e);
        PSEL <= 1'b1;
        PADDR <= a;
        PWRITE <= w;
        PWDATA <= {24'h0, d};
        @(posedge SYS_CLK);
        PENABLE <= 1'b1;
        @(posedge SYS_CLK);
        while (PREADY !== 1'b1) @(posedge SYS_CLK);
        e = PSLVERR;
        r = PRDATA;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        @(posedge SYS_CLK);
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [31:0] r;
        logic        e;
        apb(a, 1'b1, d, r, e);
    endtask : wr
    task automatic rd(input string n, input logic [11:0] a,
                      input logic [7:0] m, input logic [7:0] x);
        logic [31:0] r;
        logic        e;
        apb(a, 1'b0, 8'h00, r, e);
        chk(n, {24'h0, x}, r & {24'h0, m});
    endtask : rd
    task automatic go(input logic [7:0] k, input logic [1:0] ep);
        handshake_t h;
        host_u.send(k, ep, 1, h);
    endtask : go
    task automatic tok(input logic [7:0] k, input logic [1:0] ep,
                       input handshake_t x);
        handshake_t h;
        host_u.send(k, ep, 0, h);
        chk("handshake", {30'h0, x}, {30'h0, h});
    endtask : tok
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : test_done
    // Watchdog: the sequence needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge SYS_CLK);
        n_errors++;
        test_done;
    end
    // ==========================================================
    // Test sequence
    initial begin : seq
        logic [31:0] r;
        logic        e;
        repeat (6) @(posedge SYS_CLK);
        RSTN <= 1'b1;
        @(posedge SYS_CLK);
        rd("status", A_ST, 8'hFF, 8'h00);
        apb(12'h3FC, 1'b0, 8'h00, r, e);
        chk("slverr", 32'h1, {31'h0, e});
        $display("test reset done");
        // Acknowledged OUT, then toggle writes with and without overwrite
        wr(A_SEL, 8'h01);
        go(K_OUT, 2'h1);
        tok(K_END | K_OK, 2'h1, HS_ACK);
        go(K_HS | K_OK, 2'h1);
        rd("status", A_ST, 8'hFF, 8'h81);
        rd("done", A_FF, 8'h02, 8'h02);
        wr(A_ST, 8'h00);
        rd("status", A_ST, 8'hFF, 8'h81);
        wr(A_ST, 8'h08);
        rd("status", A_ST, 8'hFF, 8'h01);
        $display("test toggle done");
        // Corrupted packet, then a stalled OUT
        go(K_OUT, 2'h1);
        tok(K_END | K_BAD, 2'h1, HS_NONE);
        rd("status", A_ST, 8'hFF, 8'h02);
        wr(A_CTL, 8'h01);
        tok(K_OUT, 2'h1, HS_STALL);
        go(K_END, 2'h1);
        rd("status", A_ST, 8'h07, 8'h04);
        $display("test error and stall done");
        // Isochronous outcome waits for the frame start
        wr(A_SEL, 8'h02);
        wr(A_CTL, 8'h08);
        go(K_OUT, 2'h2);
        go(K_END | K_OK, 2'h2);
        rd("status", A_ST, 8'h07, 8'h00);
        go(K_SOF, 2'h2);
        rd("status", A_ST, 8'h07, 8'h01);
        $display("test isochronous done");
        // SETUP on a stalled control endpoint
        wr(A_SEL, 8'h00);
        wr(A_CTL, 8'h07);
        wr(A_ST, 8'h88);
        go(K_SET, 2'h0);
        chk("lock", 32'h1, {31'h0, FIFO_LOCKED});
        rd("status", A_ST, 8'hE0, 8'h60);
        go(K_END | K_OK, 2'h0);
        go(K_HS, 2'h0);
        rd("status", A_ST, 8'hF0, 8'h50);
        wr(A_ST, 8'h70);
        rd("status", A_ST, 8'hF0, 8'h50);
        tok(K_OUT, 2'h0, HS_NAK);
        tok(K_IN, 2'h0, HS_NAK);
        chk("lock", 32'h1, {31'h0, FIFO_LOCKED});
        wr(A_ST, 8'h00);
        chk("lock", 32'h0, {31'h0, FIFO_LOCKED});
        tok(K_OUT, 2'h0, HS_STALL);
        $display("test setup done");
        test_done;
    end
endmodule : usb_endpoint_receive_status_tb

/* usb_host_model.sv */
// Purpose: Host and engine stand-in sending token and packet events
// Assumes: Events are one-cycle pulses; endpoint field held between them
// Notes:   Gap argument lets the host answer promptly or slowly
`timescale 1ns/1ps
module usb_host_model (
    // Clock and the block's answer
    input  wire logic                   clk,
    input  wire rx_status_pkg::handshake_t hs,
    // Events towards the block
    output rx_status_pkg::sie_event_t      ev
);
    import rx_status_pkg::*;
    initial ev = '0;
    // ==========================================================
    // One pulse; answer taken at the edge where the block sees the pulse
    task automatic send(input logic [7:0] k, input logic [1:0] e,
                        input int gap, output handshake_t h);
        repeat (gap) @(posedge clk);
        ev <= {k, e};
        @(posedge clk);
        h = hs;
        ev <= {8'h00, e};
        @(posedge clk);
    endtask : send
endmodule : usb_host_model
